// ==== include/iprc_pkg.sv ====
package iprc_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CP_CTRL   = 12'h018;
    localparam logic [11:0] ADDR_ABL_MODE  = 12'h019;
    localparam logic [11:0] ADDR_RX_CTRL   = 12'h01A;
    localparam logic [11:0] ADDR_FB_SE_SEL = 12'h01B;

    // reset values
    localparam logic [7:0] RST_CP_CTRL   = 8'h00;
    localparam logic [7:0] RST_ABL_MODE  = 8'h08;
    localparam logic [7:0] RST_RX_CTRL   = 8'h00;
    localparam logic [7:0] RST_FB_SE_SEL = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // charge pump control fields
    localparam int CP_TRI_BIT = 7;
    localparam int CP_CUR_MSB = 6;
    localparam int CP_CUR_LSB = 0;
    localparam int CP_STEP_NA = 500;

    // antibacklash and pump mode fields
    localparam int ABL_MAN_BIT  = 4;
    localparam int ABL_W_MSB    = 3;
    localparam int ABL_W_LSB    = 2;
    localparam int CPM_MSB      = 1;
    localparam int CPM_LSB      = 0;
    localparam logic [7:0] ABL_MODE_MASK = 8'h1F;

    // input receiver control fields
    localparam int RX_TEST_EN_BIT = 7;
    localparam int RX_B_DIFF_BIT  = 6;
    localparam int RX_A_DIFF_BIT  = 5;
    localparam int RX_B_EN_BIT    = 4;
    localparam int RX_A_EN_BIT    = 3;
    localparam int RX_PD_CTRL_BIT = 2;
    localparam int RX_OSC_NEG_BIT = 1;
    localparam int RX_OSC_DIF_BIT = 0;

    // feedback and single-ended select fields
    localparam int FB_ZD_INT_BIT  = 5;
    localparam int FB_OSC_BIT     = 4;
    localparam int FB_ZD_SE_BIT   = 3;
    localparam int FB_ZD_DIF_BIT  = 2;
    localparam int FB_B_SE_BIT    = 1;
    localparam int FB_A_SE_BIT    = 0;
    localparam logic [7:0] FB_SE_SEL_MASK = 8'h3F;

    typedef enum logic [1:0] {
        ABL_MIN  = 2'h0,
        ABL_LOW  = 2'h1,
        ABL_HIGH = 2'h2,
        ABL_MAX  = 2'h3
    } iprc_abl_t;

    typedef enum logic [1:0] {
        CPM_TRISTATE = 2'h0,
        CPM_PUMP_UP  = 2'h1,
        CPM_PUMP_DN  = 2'h2,
        CPM_NORMAL   = 2'h3
    } iprc_cpm_t;

    // one reference receiver
    typedef struct packed {
        logic enable;
        logic differential;
        logic se_pin_sel;
    } iprc_ref_rx_t;

    // decoded analog controls
    typedef struct packed {
        logic         cp_hiz;
        logic [6:0]   cp_current_code;
        logic [15:0]  cp_current_na;
        iprc_cpm_t    cp_mode;
        iprc_abl_t    abl_period;
        logic         test_rx_en;
        iprc_ref_rx_t primary_reference_input;
        iprc_ref_rx_t secondary_reference_input;
        logic         osc_diff;
        logic         osc_se_neg;
        logic         fb_from_osc;
        logic         zero_delay_mode;
        logic         zd_internal_path;
        logic         zd_rx_en;
        logic         zd_diff;
        logic         zd_se_sel;
    } iprc_ctrl_t;
endpackage

// ==== logic/iprc_decode.sv ====
`timescale 1ns/1ps
module iprc_decode (
    input  wire logic [7:0]          cp_ctrl,
    input  wire logic [7:0]          abl_mode,
    input  wire logic [7:0]          rx_ctrl,
    input  wire logic [7:0]          fb_se_sel,
    output iprc_pkg::iprc_ctrl_t     ctrl
);
    logic [6:0] code;
    logic       zdm;

    assign code = cp_ctrl[iprc_pkg::CP_CUR_MSB:iprc_pkg::CP_CUR_LSB];
    assign zdm  = ~fb_se_sel[iprc_pkg::FB_OSC_BIT];

    // field decode into analog controls
    always_comb begin
        ctrl = '0;
        ctrl.cp_hiz          = cp_ctrl[iprc_pkg::CP_TRI_BIT];
        ctrl.cp_current_code = code;
        ctrl.cp_current_na   = 16'(32'(code) * iprc_pkg::CP_STEP_NA);
        ctrl.cp_mode = iprc_pkg::iprc_cpm_t'(abl_mode[iprc_pkg::CPM_MSB:iprc_pkg::CPM_LSB]);
        ctrl.abl_period = iprc_pkg::ABL_HIGH;
        if (abl_mode[iprc_pkg::ABL_MAN_BIT]) begin
            ctrl.abl_period = iprc_pkg::iprc_abl_t'(abl_mode[iprc_pkg::ABL_W_MSB:iprc_pkg::ABL_W_LSB]);
        end
        ctrl.test_rx_en = rx_ctrl[iprc_pkg::RX_TEST_EN_BIT];
        ctrl.primary_reference_input.differential   = rx_ctrl[iprc_pkg::RX_A_DIFF_BIT];
        ctrl.primary_reference_input.se_pin_sel     = ~rx_ctrl[iprc_pkg::RX_A_DIFF_BIT] &
                                                       fb_se_sel[iprc_pkg::FB_A_SE_BIT];
        ctrl.secondary_reference_input.differential = rx_ctrl[iprc_pkg::RX_B_DIFF_BIT];
        ctrl.secondary_reference_input.se_pin_sel   = ~rx_ctrl[iprc_pkg::RX_B_DIFF_BIT] &
                                                       fb_se_sel[iprc_pkg::FB_B_SE_BIT];
        ctrl.primary_reference_input.enable   = ~rx_ctrl[iprc_pkg::RX_PD_CTRL_BIT] |
                                                 rx_ctrl[iprc_pkg::RX_A_EN_BIT];
        ctrl.secondary_reference_input.enable = ~rx_ctrl[iprc_pkg::RX_PD_CTRL_BIT] |
                                                 rx_ctrl[iprc_pkg::RX_B_EN_BIT];
        ctrl.osc_diff   = rx_ctrl[iprc_pkg::RX_OSC_DIF_BIT];
        ctrl.osc_se_neg = ~rx_ctrl[iprc_pkg::RX_OSC_DIF_BIT] & rx_ctrl[iprc_pkg::RX_OSC_NEG_BIT];
        ctrl.fb_from_osc     = ~zdm;
        ctrl.zero_delay_mode = zdm;
        ctrl.zd_internal_path = zdm & fb_se_sel[iprc_pkg::FB_ZD_INT_BIT];
        ctrl.zd_rx_en         = zdm & ~fb_se_sel[iprc_pkg::FB_ZD_INT_BIT];
        ctrl.zd_diff   = fb_se_sel[iprc_pkg::FB_ZD_DIF_BIT];
        ctrl.zd_se_sel = ~fb_se_sel[iprc_pkg::FB_ZD_DIF_BIT] & fb_se_sel[iprc_pkg::FB_ZD_SE_BIT];
    end
endmodule

// ==== logic/iprc_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// - A set top bit of the charge pump register puts the pump output into high impedance.
// - The low seven bits of the charge pump register set the pump current in half microamp steps.
// - With manual antibacklash control off the period is forced to high and the width field ignored.
// - With manual antibacklash control on the period comes from the two-bit width field.
// - Width codes map 00 minimum, 01 low, 10 high, 11 maximum.
// - Pump mode codes map 00 tristate, 01 pump up, 10 pump down, 11 normal.
// - The test reference receiver is enabled only while its enable bit is one, off after reset.
// - Each reference receiver is differential when its bit is one, else single-ended with its pin select.
// - With power-down control off both reference receivers run, else each follows its own enable.
// - The oscillator receiver is differential on bit 0, else bit 1 picks negative or positive pin.
// - Feedback bit one takes feedback from the oscillator receiver, zero means zero delay mode.
// - In zero delay mode the type bit picks the internal channel 0 path or the external receiver.
// - The zero delay receiver is differential on its bit, else single-ended with its select bit.
module iprc_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [7:0]           wdata,
    output logic [7:0]                rdata,
    output logic                      rd_valid,
    output iprc_pkg::iprc_ctrl_t      ctrl
);
    logic [7:0]           cp_ctrl;
    logic [7:0]           abl_mode;
    logic [7:0]           rx_ctrl;
    logic [7:0]           fb_se_sel;
    logic [7:0]           next_rdata;
    iprc_pkg::iprc_ctrl_t next_ctrl;
    logic                 hit_cp;
    logic                 hit_abl;
    logic                 hit_rx;
    logic                 hit_fb;

    // address decode
    assign hit_cp  = (12'(addr) == iprc_pkg::ADDR_CP_CTRL);
    assign hit_abl = (12'(addr) == iprc_pkg::ADDR_ABL_MODE);
    assign hit_rx  = (12'(addr) == iprc_pkg::ADDR_RX_CTRL);
    assign hit_fb  = (12'(addr) == iprc_pkg::ADDR_FB_SE_SEL);

    // charge pump register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cp_ctrl <= iprc_pkg::RST_CP_CTRL;
        end else if (ce && wr_en && hit_cp) begin
            cp_ctrl <= wdata;
        end
    end

    // antibacklash and mode register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            abl_mode <= iprc_pkg::RST_ABL_MODE;
        end else if (ce && wr_en && hit_abl) begin
            abl_mode <= wdata & iprc_pkg::ABL_MODE_MASK;
        end
    end

    // receiver control register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_ctrl <= iprc_pkg::RST_RX_CTRL;
        end else if (ce && wr_en && hit_rx) begin
            rx_ctrl <= wdata;
        end
    end

    // feedback and select register, reserved top bits not stored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fb_se_sel <= iprc_pkg::RST_FB_SE_SEL;
        end else if (ce && wr_en && hit_fb) begin
            fb_se_sel <= wdata & iprc_pkg::FB_SE_SEL_MASK;
        end
    end

    // readback mux
    always_comb begin
        next_rdata = iprc_pkg::READ_UNMAPPED;
        if (hit_cp) begin
            next_rdata = cp_ctrl;
        end else if (hit_abl) begin
            next_rdata = abl_mode;
        end else if (hit_rx) begin
            next_rdata = rx_ctrl;
        end else if (hit_fb) begin
            next_rdata = fb_se_sel;
        end
    end

    // read data and valid, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata    <= 8'h00;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rdata <= next_rdata;
            end
        end
    end

    iprc_decode u_decode (
        .cp_ctrl   (cp_ctrl),
        .abl_mode  (abl_mode),
        .rx_ctrl   (rx_ctrl),
        .fb_se_sel (fb_se_sel),
        .ctrl      (next_ctrl)
    );

    // registered analog controls
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl <= '0;
            ctrl.abl_period <= iprc_pkg::ABL_HIGH;
            ctrl.primary_reference_input.enable   <= 1'b1;
            ctrl.secondary_reference_input.enable <= 1'b1;
            ctrl.zero_delay_mode <= 1'b1;
            ctrl.zd_rx_en        <= 1'b1;
        end else if (ce) begin
            ctrl <= next_ctrl;
        end
    end

    // checks on the decoded and read outputs
    AST_CP_HIZ: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && $past(nrst) |=> ctrl.cp_hiz == $past(cp_ctrl[iprc_pkg::CP_TRI_BIT]))
        else $error("pump tristate does not follow register");

    AST_CP_CURRENT: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && $past(nrst) |=> ctrl.cp_current_na ==
        16'(32'($past(cp_ctrl[iprc_pkg::CP_CUR_MSB:iprc_pkg::CP_CUR_LSB])) * iprc_pkg::CP_STEP_NA))
        else $error("pump current wrong");

    AST_ABL_AUTO: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && !abl_mode[iprc_pkg::ABL_MAN_BIT] |=> ctrl.abl_period == iprc_pkg::ABL_HIGH)
        else $error("automatic antibacklash not high");

    AST_ABL_MAN: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && abl_mode[iprc_pkg::ABL_MAN_BIT] |=>
        ctrl.abl_period == $past(abl_mode[iprc_pkg::ABL_W_MSB:iprc_pkg::ABL_W_LSB]))
        else $error("manual antibacklash not taken");

    AST_CP_MODE: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && wr_en && hit_abl ##1 ce |=>
        ctrl.cp_mode == $past(wdata[iprc_pkg::CPM_MSB:iprc_pkg::CPM_LSB], 2))
        else $error("pump mode not applied");

    AST_TEST_RX: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && wr_en && hit_rx ##1 ce |=> ctrl.test_rx_en == $past(wdata[iprc_pkg::RX_TEST_EN_BIT], 2))
        else $error("test receiver enable wrong");

    AST_TEST_RX_RST: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$past(nrst) |-> !ctrl.test_rx_en)
        else $error("test receiver on after reset");

    AST_REF_MODE: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce |=> ctrl.primary_reference_input.differential == $past(rx_ctrl[iprc_pkg::RX_A_DIFF_BIT]) &&
        ctrl.secondary_reference_input.differential == $past(rx_ctrl[iprc_pkg::RX_B_DIFF_BIT]) &&
        (ctrl.primary_reference_input.differential ||
         ctrl.primary_reference_input.se_pin_sel == $past(fb_se_sel[iprc_pkg::FB_A_SE_BIT])) &&
        (ctrl.secondary_reference_input.differential ||
         ctrl.secondary_reference_input.se_pin_sel == $past(fb_se_sel[iprc_pkg::FB_B_SE_BIT])))
        else $error("reference receiver mode wrong");

    AST_REF_PWR: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && !rx_ctrl[iprc_pkg::RX_PD_CTRL_BIT] |=>
        ctrl.primary_reference_input.enable && ctrl.secondary_reference_input.enable)
        else $error("reference receivers not both on");

    AST_REF_OWN_EN: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && rx_ctrl[iprc_pkg::RX_PD_CTRL_BIT] |=>
        ctrl.primary_reference_input.enable == $past(rx_ctrl[iprc_pkg::RX_A_EN_BIT]) &&
        ctrl.secondary_reference_input.enable == $past(rx_ctrl[iprc_pkg::RX_B_EN_BIT]))
        else $error("reference receiver own enable not followed");

    AST_OSC_SE: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && rx_ctrl[iprc_pkg::RX_OSC_DIF_BIT] |=> ctrl.osc_diff && !ctrl.osc_se_neg)
        else $error("oscillator receiver mode wrong");

    AST_FB_SRC: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && $past(nrst) |=> ctrl.fb_from_osc == $past(fb_se_sel[iprc_pkg::FB_OSC_BIT]) &&
        ctrl.zero_delay_mode == !$past(fb_se_sel[iprc_pkg::FB_OSC_BIT]))
        else $error("feedback source does not follow register");

    AST_ZD_TYPE: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && fb_se_sel[iprc_pkg::FB_OSC_BIT] |=> !ctrl.zd_rx_en && !ctrl.zd_internal_path)
        else $error("zero delay type not ignored");

    AST_ZD_MODE: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && !fb_se_sel[iprc_pkg::FB_OSC_BIT] |=>
        ctrl.zd_internal_path == $past(fb_se_sel[iprc_pkg::FB_ZD_INT_BIT]) &&
        ctrl.zd_rx_en == !$past(fb_se_sel[iprc_pkg::FB_ZD_INT_BIT]))
        else $error("zero delay path type wrong");

    AST_ZD_RX: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce |=> ctrl.zd_diff == $past(fb_se_sel[iprc_pkg::FB_ZD_DIF_BIT]) &&
        (ctrl.zd_diff || ctrl.zd_se_sel == $past(fb_se_sel[iprc_pkg::FB_ZD_SE_BIT])))
        else $error("zero delay receiver mode wrong");

    AST_ABL_RSVD: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && rd_en && hit_abl |=> (rdata & ~iprc_pkg::ABL_MODE_MASK) == 8'h00)
        else $error("reserved bits read nonzero");

    AST_RD_VALID: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && $past(nrst) |=> rd_valid == $past(rd_en))
        else $error("read valid not one cycle after request");

    COV_MANUAL_ABL: cover property (@(posedge ref_clk) disable iff (!nrst)
        ctrl.abl_period == iprc_pkg::ABL_MAX);
    COV_NORMAL_PUMP: cover property (@(posedge ref_clk) disable iff (!nrst)
        ctrl.cp_mode == iprc_pkg::CPM_NORMAL && !ctrl.cp_hiz);
    COV_INT_ZD: cover property (@(posedge ref_clk) disable iff (!nrst)
        ctrl.zd_internal_path);
    COV_READ: cover property (@(posedge ref_clk) disable iff (!nrst)
        rd_valid && rdata != 8'h00);
    COV_REF_PWRDN: cover property (@(posedge ref_clk) disable iff (!nrst)
        !ctrl.primary_reference_input.enable);
endmodule

// ==== verif/iprc_top_tb.sv ====
`timescale 1ns/1ps
module iprc_top_tb;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  rb;
    } iprc_row_t;

    logic                 ref_clk;
    logic                 nrst;
    logic                 ce;
    logic                 wr_en;
    logic                 rd_en;
    logic [11:0]          addr;
    logic [7:0]           wdata;
    logic [7:0]           rdata;
    logic                 rd_valid;
    iprc_pkg::iprc_ctrl_t ctrl;
    int                   miscompares;
    int                   total_checks;
    int                   cycles;
    logic [7:0]           sh [4];
    logic [7:0]           got;
    iprc_row_t            rows [19];

    iprc_top iprc_top_inst (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .ce       (ce),
        .wr_en    (wr_en),
        .rd_en    (rd_en),
        .addr     (addr),
        .wdata    (wdata),
        .rdata    (rdata),
        .rd_valid (rd_valid),
        .ctrl     (ctrl)
    );

    // free-running clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // expected decoded controls from the four register images
    function automatic iprc_pkg::iprc_ctrl_t model(input logic [7:0] cp, ab, rx, fb);
        iprc_pkg::iprc_ctrl_t m;
        m.cp_hiz = cp[7];
        m.cp_current_code = cp[6:0];
        m.cp_current_na = 16'(cp[6:0]) * 16'h01F4;
        m.cp_mode = iprc_pkg::iprc_cpm_t'(ab[1:0]);
        m.abl_period = ab[4] ? iprc_pkg::iprc_abl_t'(ab[3:2]) : iprc_pkg::ABL_HIGH;
        m.test_rx_en = rx[7];
        m.primary_reference_input = {(rx[2] ? rx[3] : 1'b1), rx[5], (rx[5] ? 1'b0 : fb[0])};
        m.secondary_reference_input = {(rx[2] ? rx[4] : 1'b1), rx[6], (rx[6] ? 1'b0 : fb[1])};
        m.osc_diff = rx[0];
        m.osc_se_neg = rx[0] ? 1'b0 : rx[1];
        m.fb_from_osc = fb[4];
        m.zero_delay_mode = ~fb[4];
        m.zd_internal_path = ~fb[4] & fb[5];
        m.zd_rx_en = ~fb[4] & ~fb[5];
        m.zd_diff = fb[2];
        m.zd_se_sel = fb[2] ? 1'b0 : fb[3];
        return m;
    endfunction

    task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_ctrl(input iprc_pkg::iprc_ctrl_t e);
        total_checks++;
        if (ctrl !== e) begin
            miscompares++;
            $display("ERROR ctrl expected %h seen %h", e, ctrl);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge ref_clk);
        #1 wr_en = 1'b0;
    endtask

    // one-cycle read strobe, answer one cycle later
    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        #1 rd_en = 1'b1;
        addr = a;
        @(posedge ref_clk);
        #1 rd_en = 1'b0;
        chk_byte("rd_valid", 8'h01, {7'h00, rd_valid});
        q = rdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic check_all();
        chk_ctrl(model(sh[0], sh[1], sh[2], sh[3]));
        for (int i = 0; i < 4; i++) begin
            rd(12'h018 + 12'(i), got);
            chk_byte("register", sh[i], got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // cycle limit against hangs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("ERROR cycle_limit expected %0d seen %0d", 2999, cycles);
            finish_test();
        end
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wdata = 8'h00;
        miscompares = 0;
        total_checks = 0;
        cycles = 0;
        sh = '{8'h00, 8'h08, 8'h00, 8'h00};
        // feedback rows keep bits 7:6 zero
        rows = '{'{12'h018, 8'h80, 8'h80}, '{12'h018, 8'h7F, 8'h7F}, '{12'h019, 8'hE1, 8'h01},
                 '{12'h019, 8'h12, 8'h12}, '{12'h019, 8'h17, 8'h17}, '{12'h019, 8'h1A, 8'h1A},
                 '{12'h019, 8'h1C, 8'h1C}, '{12'h019, 8'h0D, 8'h0D}, '{12'h01A, 8'h80, 8'h80},
                 '{12'h01A, 8'h64, 8'h64}, '{12'h01A, 8'h1C, 8'h1C}, '{12'h01A, 8'h0C, 8'h0C},
                 '{12'h01A, 8'h0B, 8'h0B}, '{12'h01A, 8'h02, 8'h02}, '{12'h01B, 8'h03, 8'h03},
                 '{12'h01B, 8'h10, 8'h10}, '{12'h01B, 8'h20, 8'h20}, '{12'h01B, 8'h0C, 8'h0C},
                 '{12'h01B, 8'h08, 8'h08}};
        repeat (8) @(posedge ref_clk);
        #1 nrst = 1'b1;
        check_all();
        // table of writes, decoded controls and readback
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            sh[rows[i].a[1:0]] = rows[i].rb;
            settle();
            chk_ctrl(model(sh[0], sh[1], sh[2], sh[3]));
            rd(rows[i].a, got);
            chk_byte("readback", rows[i].rb, got);
        end
        // unmapped place: write ignored, read gives zero
        wr(12'h017, 8'hFF);
        settle();
        check_all();
        rd(12'h01C, got);
        chk_byte("unmapped", 8'h00, got);
        // clock enable low freezes the registers
        ce = 1'b0;
        wr(12'h018, 8'h55);
        ce = 1'b1;
        settle();
        check_all();
        // read and write in one cycle returns the old value
        @(posedge ref_clk);
        #1 wr_en = 1'b1;
        rd_en = 1'b1;
        addr = 12'h018;
        wdata = 8'h3C;
        @(posedge ref_clk);
        #1 wr_en = 1'b0;
        rd_en = 1'b0;
        chk_byte("same_cycle", sh[0], rdata);
        sh[0] = 8'h3C;
        settle();
        check_all();
        // reset in mid-run restores defaults
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1'b1;
        sh = '{8'h00, 8'h08, 8'h00, 8'h00};
        check_all();
        finish_test();
    end
endmodule
